/* File: rtl/ptd_top.sv */
// Palette test diagnostics: data flow check, identification read, per-frame
// ones accumulation and analog comparator select and capture.
// Assumes an Avalon-MM master, palette bytes and video inputs synchronous to clk_sys.
//
// Summary of operation
// - One location: writes set the control word, reads return the selected channel.
// - Selector 000-010 palette RGB, 011 ident, 100-110 accumulation RGB, 111 analog.
// - Palette channel read returns current entry's colour byte before width shift.
// - Palette channel read advances red, green, blue, blue wrapping to red.
// - Ident read returns a fixed byte always, then selector moves to red.
// - Selector returns to ident only by writing the ident code.
// - Accumulation adds ones of chosen byte of every second accessed palette word.
// - All eight bits counted even in reduced six-bit mode.
// - Monitored colour changes only between frames.
// - Accumulator is eight bits and drops overflow.
// - Accumulation runs at half the pixel clock rate.
// - Vsync falling edge copies accumulator to result, then clears accumulator.
// - Result updates only on the vsync pin falling edge.
// - Before next frame the selector is rewritten to another colour.
// - Code 111 enables analog test; upper four bits select, bit 3 result.
// - Compare codes 1010, 1001, 0110, 0101; one means first signal greater.
// - Comparator result latched on falling edge of blanking-derived strobe.
//
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`default_nettype none

module ptd_top #(
  parameter logic [7:0] IDENT_CODE = ptd_pkg::IDENT_DEFAULT  // Arbitrary value.
) (
  input  wire logic        clk_sys,          // System clock, 50 MHz.
  input  wire logic        srst,             // Synchronous reset, active high.
  input  wire logic [1:0]  avs_address,      // Avalon word address.
  input  wire logic        avs_read,         // Avalon read request.
  input  wire logic        avs_write,        // Avalon write request.
  input  wire logic [31:0] avs_writedata,    // Avalon write data.
  input  wire logic [3:0]  avs_byteenable,   // Avalon byte enables.
  output logic      [31:0] avs_readdata,     // Avalon read data, registered.
  output logic             avs_waitrequest,  // Avalon wait request.
  input  wire logic        pixel_clock_in,   // Pixel clock level.
  input  wire logic        vsync_in,         // Vertical sync pin level.
  input  wire logic        blank_in_n,       // Blanking input, active low.
  input  wire logic [7:0]  pal_red,          // Red byte of addressed palette entry.
  input  wire logic [7:0]  pal_green,        // Green byte of addressed palette entry.
  input  wire logic [7:0]  pal_blue,         // Blue byte of addressed palette entry.
  input  wire logic        cmp_result_in,    // Analog comparator output.
  output logic      [3:0]  cmp_select,       // Comparator input selects.
  output logic             analog_test_on    // High while the analog test runs.
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    ptd_pkg::ptd_chan_t sel;
    logic [3:0]         cmp_sel;
    logic               cmp_res;
    logic               ack;
    logic [7:0]         rdata;
    logic               vs_q;
    logic               bl_q;
    logic [7:0]         result;
    logic [1:0]         frame_col;
  } ptd_state_t;

  ptd_state_t st;
  ptd_state_t next_st;
  logic [7:0] acc;
  logic       vs_fall;
  logic       bl_fall;
  logic       req;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Next colour index in red, green, blue order, blue wrapping to red.
  function automatic logic [1:0] next_col(input logic [1:0] c);
    logic [1:0] n;
    n = ptd_pkg::COL_RED;
    unique case (c)
      ptd_pkg::COL_RED:   n = ptd_pkg::COL_GREEN;
      ptd_pkg::COL_GREEN: n = ptd_pkg::COL_BLUE;
      default:            n = ptd_pkg::COL_RED;
    endcase
    return n;
  endfunction

  // Colour byte of the current palette word for a colour index.
  function automatic logic [7:0] col_byte(input logic [1:0] c,
                                          input logic [7:0] r,
                                          input logic [7:0] g,
                                          input logic [7:0] b);
    logic [7:0] v;
    v = r;
    unique case (c)
      ptd_pkg::COL_GREEN: v = g;
      ptd_pkg::COL_BLUE:  v = b;
      default:            v = r;
    endcase
    return v;
  endfunction

  // True for the three accumulation channel codes.
  function automatic logic is_acc(input ptd_pkg::ptd_chan_t s);
    return s[2] && (s[1:0] != 2'h3);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on the video inputs, which are already in this domain.

  // Only the pin edge counts; composite sync never reaches this logic.
  assign vs_fall = st.vs_q && !vsync_in;
  assign bl_fall = st.bl_q && !blank_in_n;
  assign req     = avs_read || avs_write;

  // Each request waits one cycle, so the answer is always registered.
  assign avs_waitrequest = req && !st.ack;

  ////////////////////////////////////////////////////////////////////////////
  // Ones accumulator on the monitored colour of this frame.

  ptd_ones_acc u_acc (
    .clk_sys        (clk_sys),
    .srst           (srst),
    .pixel_clock_in (pixel_clock_in),
    .mon_byte       (col_byte(st.frame_col, pal_red, pal_green, pal_blue)),
    .clear          (vs_fall),
    .acc            (acc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic. A host write in the same cycle as the frame edge wins
  // over the automatic selector change, since software intent must not be lost.

  always_comb begin
    next_st      = st;
    next_st.vs_q = vsync_in;
    next_st.bl_q = blank_in_n;
    next_st.ack  = req && !st.ack;

    // Frame boundary: capture the sum and move to the next colour.
    if (vs_fall) begin
      next_st.result = acc;
      if (is_acc(st.sel)) begin
        next_st.sel = ptd_pkg::ptd_chan_t'({1'b1, next_col(st.sel[1:0])});
      end
    end

    // Comparator capture on the blanking strobe while the analog test runs.
    if (bl_fall && (st.sel == ptd_pkg::CHAN_ANALOG)) begin
      next_st.cmp_res = cmp_result_in;
    end

    // Bus access, performed once in the cycle that raises the acknowledge.
    if (req && !st.ack) begin
      if (avs_write) begin
        if ((avs_address == ptd_pkg::ADDR_DIAG) && avs_byteenable[0]) begin
          next_st.sel     = ptd_pkg::ptd_chan_t'(avs_writedata[ptd_pkg::SEL_MSB:ptd_pkg::SEL_LSB]);
          next_st.cmp_sel = avs_writedata[ptd_pkg::CMP_MSB:ptd_pkg::CMP_LSB];
        end
      end else if (avs_address != ptd_pkg::ADDR_DIAG) begin
        next_st.rdata = 8'h00;
      end else begin
        unique case (st.sel)
          ptd_pkg::CHAN_PAL_RED, ptd_pkg::CHAN_PAL_GREEN, ptd_pkg::CHAN_PAL_BLUE: begin
            next_st.rdata = col_byte(st.sel[1:0], pal_red, pal_green, pal_blue);
            next_st.sel   = ptd_pkg::ptd_chan_t'({1'b0, next_col(st.sel[1:0])});
          end
          ptd_pkg::CHAN_IDENT: begin
            next_st.rdata = IDENT_CODE;
            next_st.sel   = ptd_pkg::CHAN_PAL_RED;
          end
          ptd_pkg::CHAN_ACC_RED, ptd_pkg::CHAN_ACC_GREEN, ptd_pkg::CHAN_ACC_BLUE: begin
            next_st.rdata = st.result;
          end
          ptd_pkg::CHAN_ANALOG: begin
            next_st.rdata = {st.cmp_sel, st.cmp_res, ptd_pkg::CHAN_ANALOG};
          end
        endcase
      end
    end

    // The monitored colour follows the selector only at the frame edge.
    if (vs_fall && is_acc(next_st.sel)) begin
      next_st.frame_col = next_st.sel[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st.sel       <= ptd_pkg::RST_SEL;
      st.cmp_sel   <= ptd_pkg::RST_CMP_SEL;
      st.cmp_res   <= 1'b0;
      st.ack       <= 1'b0;
      st.rdata     <= ptd_pkg::RST_BYTE;
      st.vs_q      <= 1'b1;
      st.bl_q      <= 1'b1;
      st.result    <= ptd_pkg::RST_BYTE;
      st.frame_col <= ptd_pkg::RST_COL;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign avs_readdata   = {24'h00_0000, st.rdata};
  assign cmp_select     = st.cmp_sel;
  assign analog_test_on = (st.sel == ptd_pkg::CHAN_ANALOG);

endmodule // ptd_top

`default_nettype wire

/* File: rtl/ptd_pkg.sv */
// Package for the palette test diagnostics block: register map, channel codes,
// comparator select codes and reset values.
// Assumes a 32-bit Avalon-MM slave port with a word address.
package ptd_pkg;

  // Register map, word address on the Avalon port.
  localparam logic [1:0] ADDR_DIAG = 2'h0;     // Diagnostic select and result.

  // Channel selector, three bits in the low data bits.
  typedef enum logic [2:0] {
    CHAN_PAL_RED   = 3'h0,
    CHAN_PAL_GREEN = 3'h1,
    CHAN_PAL_BLUE  = 3'h2,
    CHAN_IDENT     = 3'h3,
    CHAN_ACC_RED   = 3'h4,
    CHAN_ACC_GREEN = 3'h5,
    CHAN_ACC_BLUE  = 3'h6,
    CHAN_ANALOG    = 3'h7
  } ptd_chan_t;

  // Colour index used by both the palette and accumulation channels.
  localparam logic [1:0] COL_RED   = 2'h0;
  localparam logic [1:0] COL_GREEN = 2'h1;
  localparam logic [1:0] COL_BLUE  = 2'h2;

  // Field positions in the data word.
  localparam int SEL_LSB    = 0;
  localparam int SEL_MSB    = 2;
  localparam int RESULT_BIT = 3;
  localparam int CMP_LSB    = 4;
  localparam int CMP_MSB    = 7;

  // Comparator select codes, first-named signal greater reads as one.
  localparam logic [3:0] CMP_NORMAL     = 4'h0;
  localparam logic [3:0] CMP_RED_BLUE   = 4'hA;
  localparam logic [3:0] CMP_RED_REF    = 4'h9;
  localparam logic [3:0] CMP_GREEN_BLUE = 4'h6;
  localparam logic [3:0] CMP_GREEN_REF  = 4'h5;

  // Values after reset.
  localparam ptd_chan_t  RST_SEL     = CHAN_IDENT;
  localparam logic [3:0] RST_CMP_SEL = 4'h0;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [1:0] RST_COL     = 2'h0;

  // Identification byte; the value is arbitrary.
  localparam logic [7:0] IDENT_DEFAULT = 8'h5A;

endpackage

/* File: rtl/ptd_ones_acc.sv */
// Ones accumulator: counts the one bits of a monitored colour byte at half the
// pixel rate and keeps an 8-bit wrapping sum.
// Assumes the pixel clock arrives as a level synchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none

module ptd_ones_acc (
  input  wire logic       clk_sys,          // System clock.
  input  wire logic       srst,             // Synchronous reset, active high.
  input  wire logic       pixel_clock_in,   // Pixel clock level.
  input  wire logic [7:0] mon_byte,         // Monitored colour byte.
  input  wire logic       clear,            // Frame boundary: restart the sum.
  output logic      [7:0] acc               // Running sum, registered.
);

  typedef struct packed {
    logic [7:0] acc;
    logic       phase;
    logic       pix_q;
  } ptd_acc_state_t;

  ptd_acc_state_t st;
  ptd_acc_state_t next_st;

  // Population count over all eight bits, regardless of the converter width.
  function automatic logic [7:0] ones8(input logic [7:0] b);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < 8; i++) begin
      n = n + {7'h00, b[i]};
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Only every second pixel edge adds, so the adder keeps half-rate timing.
  always_comb begin
    next_st = st;
    next_st.pix_q = pixel_clock_in;
    if (pixel_clock_in && !st.pix_q) begin
      next_st.phase = ~st.phase;
      if (st.phase) begin
        next_st.acc = st.acc + ones8(mon_byte);
      end
    end
    if (clear) begin
      next_st.acc = 8'h00;
    end
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign acc = st.acc;

endmodule // ptd_ones_acc

`default_nettype wire

/* File: dv/ptd_checker.sv */
// Checker for ptd_top: bus handshake, selects and analog mode.
// Assumes binding to ptd_top, one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module ptd_checker (
  input wire logic        clk_sys,         // Clock.
  input wire logic        srst,            // Reset.
  input wire logic [1:0]  avs_address,     // Address.
  input wire logic        avs_read,        // Read.
  input wire logic        avs_write,       // Write.
  input wire logic [31:0] avs_writedata,   // Write data.
  input wire logic [3:0]  avs_byteenable,  // Byte enables.
  input wire logic [31:0] avs_readdata,    // Read data.
  input wire logic        avs_waitrequest, // Stall.
  input wire logic        vsync_in,        // Vertical sync.
  input wire logic [3:0]  cmp_select,      // Compare selects.
  input wire logic        analog_test_on   // Analog mode.
);
  // A write the block takes; ignored writes must leave state alone.
  wire wr_take = avs_write & avs_waitrequest & (avs_address == 2'h0) & avs_byteenable[0];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  AST_RESET_VALS: assert property ($past(srst) |-> cmp_select == 4'h0 && !analog_test_on)
    else $error("bad values after reset");
  AST_ANALOG_ENTER: assert property (wr_take |=> analog_test_on == ($past(avs_writedata[2:0]) == 3'h7))
    else $error("analog mode does not follow written selector");
  AST_CMP_WRITE: assert property (wr_take |=> cmp_select == $past(avs_writedata[7:4]))
    else $error("compare selects not written");
  AST_CMP_HOLD: assert property (!wr_take |=> $stable(cmp_select))
    else $error("compare selects moved without a write");
  AST_ANALOG_KEEP: assert property (!wr_take |=> analog_test_on == $past(analog_test_on))
    else $error("analog mode changed without a write");
  AST_READ_HIGH: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == '0)
    else $error("upper read bits not zero");
  AST_ANALOG_READ: assert property (avs_read && !avs_waitrequest && analog_test_on
    |-> avs_readdata[7:4] == cmp_select && avs_readdata[2:0] == 3'h7)
    else $error("analog read word wrong");
  C_WR: cover property (wr_take);
  C_ARD: cover property (avs_read && !avs_waitrequest && analog_test_on);
  C_VS: cover property ($fell(vsync_in));
endmodule // ptd_checker
bind ptd_top ptd_checker chk_u (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .vsync_in(vsync_in), .cmp_select(cmp_select), .analog_test_on(analog_test_on));
`default_nettype wire

/* File: dv/ptd_host.sv */
// Host model: an Avalon-MM master issuing single transfers.
// Assumes calls start just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module ptd_host (
  input  wire logic        clk_sys,         // Clock.
  input  wire logic        avs_waitrequest, // Stall.
  output logic      [1:0]  avs_address,     // Address.
  output logic             avs_read,        // Read.
  output logic             avs_write,       // Write.
  output logic      [31:0] avs_writedata,   // Write data.
  output logic      [3:0]  avs_byteenable   // Byte enables.
);
  initial begin
    avs_address = 2'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h1;
  end
  // Hold the request until waitrequest is low, then idle one cycle.
  task automatic req(input logic rd, input logic [1:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_read <= rd;
    avs_write <= !rd;
    @(posedge clk_sys);
    while (avs_waitrequest) @(posedge clk_sys);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule // ptd_host
`default_nettype wire

/* File: dv/ptd_tb_top.sv */
// Testbench for ptd_top: reads checked against a queue of expectations.
// Assumes ptd_pkg, ptd_top, ptd_host and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module ptd_tb_top;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [1:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, cmp_select;
  logic pixel_clock_in, vsync_in, blank_in_n, cmp_result_in, analog_test_on, r;
  logic [7:0] pal_red, pal_green, pal_blue, pk;
  logic [7:0] c [3];
  logic [31:0] exp_q [$];
  int errors = 0;
  int compares = 0;
  integer seed = 32'h7d55;
  int k [4] = '{40, 7, 9, 5};
  int m [4] = '{1, 2, 2, 0};
  logic [3:0] codes [4] = '{4'hA, 4'h9, 4'h6, 4'h5};
  always #10 clk_sys = ~clk_sys;
  ptd_top dut_u (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pixel_clock_in(pixel_clock_in),
    .vsync_in(vsync_in), .blank_in_n(blank_in_n), .pal_red(pal_red), .pal_green(pal_green),
    .pal_blue(pal_blue), .cmp_result_in(cmp_result_in), .cmp_select(cmp_select),
    .analog_test_on(analog_test_on));
  ptd_host host_u (.clk_sys(clk_sys), .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Note the expected byte first, so the monitor always finds it.
  task automatic rd_exp(input logic [7:0] e, input logic [1:0] a = 2'h0);
    exp_q.push_back({24'h00_0000, e});
    host_u.req(1'b1, a, 8'h00);
  endtask
  // Pixel clock stays well under half the system rate so no edge is lost.
  task automatic pix(input int n);
    repeat (n) begin
      pixel_clock_in <= 1'b1;
      wait_clk(2);
      pixel_clock_in <= 1'b0;
      wait_clk(2);
    end
  endtask
  task automatic vfall();
    vsync_in <= 1'b0;
    wait_clk(3);
    vsync_in <= 1'b1;
    wait_clk(3);
  endtask
  ////////////////////////////////////////////////////////////
  // Each completed read takes the oldest expectation.
  always @(posedge clk_sys) begin
    if (avs_read && !avs_waitrequest) begin
      check(avs_readdata, exp_q.pop_front());
    end
  end
  initial begin
    wait_clk(20000);
    errors++;
    close_out();
  end
  initial begin
    for (int j = 0; j < 3; j++) c[j] = 8'($random(seed));
    {pal_red, pal_green, pal_blue} = {c[0], c[1], c[2]};
    {pixel_clock_in, vsync_in, blank_in_n, cmp_result_in} = 4'h6;
    wait_clk(4);
    srst <= 1'b0;
    wait_clk(1);
    rd_exp(ptd_pkg::IDENT_DEFAULT);
    for (int i = 0; i < 5; i++) rd_exp(c[i % 3]);
    host_u.req(1'b0, 2'h0, 8'h01);
    for (int i = 1; i < 4; i++) rd_exp(c[i % 3]);
    host_u.req(1'b0, 2'h0, 8'h03);
    rd_exp(ptd_pkg::IDENT_DEFAULT);
    rd_exp(8'h00, 2'h1);
    host_u.req(1'b0, 2'h1, 8'h07);
    // Frames run green, blue, blue, red; a mid-frame write must not move the byte watched.
    host_u.req(1'b0, 2'h0, 8'h04);
    vfall();
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 3; j++) c[j] = 8'($random(seed));
      if (i == 0) c[1] = 8'hFF;
      {pal_red, pal_green, pal_blue} <= {c[0], c[1], c[2]};
      pix(k[i]);
      if (i == 1) host_u.req(1'b0, 2'h0, 8'h05);
      pix(k[i]);
      vfall();
      pk = 8'(k[i] * $countones(c[m[i]]));
      rd_exp(pk);
      rd_exp(pk);
    end
    // Result must be the value latched at the blanking fall, not the live input.
    foreach (codes[i]) begin
      host_u.req(1'b0, 2'h0, {codes[i], 4'h7});
      r = 1'($random(seed));
      cmp_result_in <= r;
      wait_clk(1);
      blank_in_n <= 1'b0;
      wait_clk(3);
      blank_in_n <= 1'b1;
      cmp_result_in <= ~r;
      wait_clk(2);
      rd_exp({codes[i], r, 3'h7});
    end
    host_u.req(1'b0, 2'h0, 8'h03);
    rd_exp(ptd_pkg::IDENT_DEFAULT);
    wait_clk(4);
    close_out();
  end
endmodule // ptd_tb_top
`default_nettype wire
